// ===== hw/lpmc_cfg.svh
// constants of the low power mode controller
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH
`define LPMC_CLK_HZ        10000000
`define LPMC_VLP_CORE_HZ   4000000
`define LPMC_VLP_FLASH_HZ  1000000
`define LPMC_WAKE_SYNC_LEN 2
`endif

// ===== hw/lpmc_pkg.sv
// types of the low power mode controller
package lpmc_pkg;
	typedef enum logic [2:0]
	{
		MODE_RUN   = 3'h0,
		MODE_HIGH_SPEED_RUN_MODE = 3'h1,
		MODE_WAIT  = 3'h2,
		MODE_STOP  = 3'h3,
		MODE_VERY_LOW_POWER_RUN  = 3'h4,
		MODE_VERY_LOW_POWER_WAIT  = 3'h5,
		MODE_VERY_LOW_POWER_STOP  = 3'h6
	} lpmc_mode_type;

	// requests from the core and from software
	typedef struct packed
	{
		logic wait_for_interrupt_instruction;
		logic deep;
		logic go_high_speed_run_mode;
		logic go_very_low_power_run;
		logic go_run;
	} lpmc_req_type;

	// per mode controls driven to the chip
	typedef struct packed
	{
		logic core_clk_en;
		logic periph_clk_en;
		logic free_running_core_clock_en;
		logic nested_interrupt_controller_en;
		logic async_wakeup_interrupt_controller_en;
		logic reg_full_power;
		logic lvd_en;
		logic flash_slow;
		logic vlp_osc_sel;
		logic hs_clk_sel;
		logic pin_hold;
		logic sram_retain;
		logic analog_wake_en;
	} lpmc_ctrl_type;

	typedef struct packed
	{
		lpmc_mode_type mode;
		lpmc_ctrl_type ctrl;
		logic          rejected;
	} lpmc_state_type;

	typedef struct packed
	{
		logic s1;
		logic s2;
	} lpmc_sync_type;
endpackage

// ===== hw/lpmc_sync.sv
// two flop synchroniser for the wake-up line
`timescale 1ns/10ps
module lpmc_sync
(
	input  wire logic CLK,
	input  wire logic SRST,
	input  wire logic CE,
	input  wire logic D,
	output logic      Q
);
	lpmc_pkg::lpmc_sync_type r;
	lpmc_pkg::lpmc_sync_type next_r;

	always_comb
	begin
		next_r = r;
		if (CE)
		begin
			next_r.s1 = D;
			next_r.s2 = r.s1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			r <= '0;
		else
			r <= next_r;
	end

	assign Q = r.s2;
endmodule

// ===== hw/lpmc_top.sv
// low power mode controller: sequences run, wait and stop modes
`timescale 1ns/10ps
`include "lpmc_cfg.svh"
// How it works
// - reset lands in normal run with the regulator at full power
// - stop is never entered from high-speed run; go back to run first
// - run and very-low-power run each lead to their own wait and stop
// - the core's wait-for-interrupt is the only way into wait or stop
// - pin hold stays asserted in every mode
// - normal wait: core sleeps, peripherals clocked, interrupt wakes
// - normal stop keeps registers and low voltage detect alive
// - normal stop gates peripheral clocks; async controller wakes
// - very-low-power run selects the 4 MHz internal oscillator
// - very-low-power wait keeps run settings, core asleep, free_running_core_clock on
// - very-low-power stop: detect off, clocks stopped, analog wake on
// - very-low-power stop: free_running_core_clock off, async wake, sram kept
// - high-speed run selects the faster clock with core awake
module lpmc_top
(
	input  wire logic               CLK,
	input  wire logic               SRST,
	input  wire logic               CE,
	input  wire lpmc_pkg::lpmc_req_type REQ,
	input  wire logic               IRQ,
	input  wire logic               ASYNC_WAKE,
	output lpmc_pkg::lpmc_mode_type MODE,
	output lpmc_pkg::lpmc_ctrl_type CTRL,
	output logic                    STOP_REJECTED
);
	lpmc_pkg::lpmc_state_type r;
	lpmc_pkg::lpmc_state_type next_r;
	logic                     wake_sync;
	logic                     wake;

	// the asynchronous wake line comes from outside the clock domain
	lpmc_sync u_sync
	(
		.CLK  (CLK),
		.SRST (SRST),
		.CE   (CE),
		.D    (ASYNC_WAKE),
		.Q    (wake_sync)
	);

	// stop modes listen to the synchronised async line and to IRQ, wait modes to IRQ alone
	always_comb
	begin
		case (r.mode)
			lpmc_pkg::MODE_STOP,
			lpmc_pkg::MODE_VERY_LOW_POWER_STOP: wake = wake_sync | IRQ;
			default:             wake = IRQ;
		endcase
	end

	function automatic lpmc_pkg::lpmc_ctrl_type ctrl_of
	(
		input lpmc_pkg::lpmc_mode_type m
	);
		lpmc_pkg::lpmc_ctrl_type c;
		c = '0;
		c.pin_hold       = 1'b1;
		c.sram_retain    = 1'b1;
		c.core_clk_en    = 1'b1;
		c.periph_clk_en  = 1'b1;
		c.free_running_core_clock_en        = 1'b1;
		c.nested_interrupt_controller_en        = 1'b1;
		c.reg_full_power = 1'b1;
		c.lvd_en         = 1'b1;
		case (m)
			lpmc_pkg::MODE_HIGH_SPEED_RUN_MODE: c.hs_clk_sel = 1'b1;
			lpmc_pkg::MODE_WAIT:  c.core_clk_en = 1'b0;
			lpmc_pkg::MODE_STOP:
			begin
				c.core_clk_en   = 1'b0;
				c.periph_clk_en = 1'b0;
				c.free_running_core_clock_en       = 1'b0;
				c.nested_interrupt_controller_en       = 1'b0;
				c.async_wakeup_interrupt_controller_en       = 1'b1; // lvd stays on
			end
			lpmc_pkg::MODE_VERY_LOW_POWER_RUN,
			lpmc_pkg::MODE_VERY_LOW_POWER_WAIT,
			lpmc_pkg::MODE_VERY_LOW_POWER_STOP:
			begin
				c.reg_full_power = 1'b0;
				c.lvd_en         = 1'b0;
				c.flash_slow     = 1'b1;
				c.vlp_osc_sel    = 1'b1;
				if (m == lpmc_pkg::MODE_VERY_LOW_POWER_WAIT)
					c.core_clk_en = 1'b0;
				if (m == lpmc_pkg::MODE_VERY_LOW_POWER_STOP)
				begin
					c.core_clk_en    = 1'b0;
					c.periph_clk_en  = 1'b0;
					c.free_running_core_clock_en        = 1'b0;
					c.nested_interrupt_controller_en        = 1'b0;
					c.async_wakeup_interrupt_controller_en        = 1'b1;
					c.analog_wake_en = 1'b1;
				end
			end
			default: c = c;
		endcase
		return c;
	endfunction

	always_comb
	begin
		next_r          = r;
		next_r.rejected = 1'b0;
		case (r.mode)
			lpmc_pkg::MODE_RUN:
			begin
				if (REQ.wait_for_interrupt_instruction)
					next_r.mode = REQ.deep ? lpmc_pkg::MODE_STOP
						: lpmc_pkg::MODE_WAIT;
				else if (REQ.go_high_speed_run_mode)
					next_r.mode = lpmc_pkg::MODE_HIGH_SPEED_RUN_MODE;
				else if (REQ.go_very_low_power_run)
					next_r.mode = lpmc_pkg::MODE_VERY_LOW_POWER_RUN;
			end
			lpmc_pkg::MODE_HIGH_SPEED_RUN_MODE:
			begin
				if (REQ.wait_for_interrupt_instruction && REQ.deep)
					next_r.rejected = 1'b1;
				else if (REQ.wait_for_interrupt_instruction)
					next_r.mode = lpmc_pkg::MODE_WAIT;
				else if (REQ.go_run)
					next_r.mode = lpmc_pkg::MODE_RUN;
			end
			lpmc_pkg::MODE_VERY_LOW_POWER_RUN:
			begin
				if (REQ.wait_for_interrupt_instruction)
					next_r.mode = REQ.deep ? lpmc_pkg::MODE_VERY_LOW_POWER_STOP
						: lpmc_pkg::MODE_VERY_LOW_POWER_WAIT;
				else if (REQ.go_run)
					next_r.mode = lpmc_pkg::MODE_RUN;
			end
			// normal wait and stop return to run on wake; wait may come from run or high-speed run
			lpmc_pkg::MODE_WAIT,
			lpmc_pkg::MODE_STOP:
				if (wake)
					next_r.mode = lpmc_pkg::MODE_RUN;
			lpmc_pkg::MODE_VERY_LOW_POWER_WAIT,
			lpmc_pkg::MODE_VERY_LOW_POWER_STOP:
				if (wake)
					next_r.mode = lpmc_pkg::MODE_VERY_LOW_POWER_RUN;
			default: next_r.mode = lpmc_pkg::MODE_RUN;
		endcase
		next_r.ctrl = ctrl_of(next_r.mode);
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			r          <= '0;
			r.mode     <= lpmc_pkg::MODE_RUN;
			r.ctrl     <= ctrl_of(lpmc_pkg::MODE_RUN);
		end
		else if (CE)
			r <= next_r;
	end

	assign MODE          = r.mode;
	assign CTRL          = r.ctrl;
	assign STOP_REJECTED = r.rejected;

	reset_run_a: assert property (@(posedge CLK)
		SRST |=> MODE == lpmc_pkg::MODE_RUN && CTRL.reg_full_power)
		else $error("not in full power run after reset");
	no_hs_stop_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_HIGH_SPEED_RUN_MODE |=> MODE != lpmc_pkg::MODE_STOP
		&& MODE != lpmc_pkg::MODE_VERY_LOW_POWER_STOP)
		else $error("stop entered from high-speed run");
	wfi_trigger_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && !REQ.wait_for_interrupt_instruction && (MODE == lpmc_pkg::MODE_RUN
		|| MODE == lpmc_pkg::MODE_VERY_LOW_POWER_RUN) |=> !CTRL.core_clk_en == 1'b0)
		else $error("core slept without wait instruction");
	pins_held_a: assert property (@(posedge CLK) disable iff (SRST)
		CTRL.pin_hold)
		else $error("pin hold dropped");
	wait_wake_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && IRQ && MODE == lpmc_pkg::MODE_WAIT
		|=> MODE == lpmc_pkg::MODE_RUN && CTRL.core_clk_en)
		else $error("normal wait did not wake on interrupt");
	stop_ctrl_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_STOP |-> !CTRL.periph_clk_en
		&& !CTRL.nested_interrupt_controller_en && CTRL.async_wakeup_interrupt_controller_en && CTRL.lvd_en)
		else $error("normal stop controls wrong");
	very_low_power_run_ctrl_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_VERY_LOW_POWER_RUN |-> !CTRL.reg_full_power
		&& !CTRL.lvd_en && CTRL.flash_slow && CTRL.vlp_osc_sel)
		else $error("very-low-power run controls wrong");
	very_low_power_stop_ctrl_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_VERY_LOW_POWER_STOP |-> !CTRL.free_running_core_clock_en && CTRL.async_wakeup_interrupt_controller_en
		&& CTRL.analog_wake_en && CTRL.sram_retain)
		else $error("very-low-power stop controls wrong");
	hs_reject_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && MODE == lpmc_pkg::MODE_HIGH_SPEED_RUN_MODE && REQ.wait_for_interrupt_instruction && REQ.deep
		|=> STOP_REJECTED && MODE == lpmc_pkg::MODE_HIGH_SPEED_RUN_MODE)
		else $error("stop in high-speed run not rejected");

	// per mode control sets; a slip here would gate the wrong clock
	wait_ctrl_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_WAIT |-> !CTRL.core_clk_en
		&& CTRL.periph_clk_en && CTRL.nested_interrupt_controller_en)
		else $error("normal wait controls wrong");
	stop_keep_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_STOP |-> CTRL.sram_retain && CTRL.lvd_en
		&& CTRL.reg_full_power)
		else $error("normal stop lost retention or detect");
	very_low_power_wait_ctrl_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_VERY_LOW_POWER_WAIT |-> !CTRL.core_clk_en && CTRL.free_running_core_clock_en
		&& CTRL.nested_interrupt_controller_en && CTRL.flash_slow && !CTRL.reg_full_power)
		else $error("very-low-power wait controls wrong");
	very_low_power_stop_lvd_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_VERY_LOW_POWER_STOP |-> !CTRL.lvd_en
		&& !CTRL.periph_clk_en && !CTRL.nested_interrupt_controller_en)
		else $error("very-low-power stop detect or clocks on");
	hs_ctrl_a: assert property (@(posedge CLK) disable iff (SRST)
		MODE == lpmc_pkg::MODE_HIGH_SPEED_RUN_MODE |-> CTRL.core_clk_en
		&& CTRL.hs_clk_sel && !CTRL.vlp_osc_sel)
		else $error("high-speed run controls wrong");
	vlp_sleep_a: assert property (@(posedge CLK) disable iff (SRST)
		CE && MODE == lpmc_pkg::MODE_VERY_LOW_POWER_RUN && REQ.wait_for_interrupt_instruction
		|=> MODE == lpmc_pkg::MODE_VERY_LOW_POWER_WAIT || MODE == lpmc_pkg::MODE_VERY_LOW_POWER_STOP)
		else $error("very-low-power run slept into wrong mode");
endmodule

// ===== testbench/lpmc_core_model.sv
// core model issuing sleep and mode requests
`timescale 1ns/10ps
module lpmc_core_model
(
	input  wire logic              CLK,
	input  wire logic [2:0]        op,
	output lpmc_pkg::lpmc_req_type req = '0
);
	// one request kind per cycle, so priority never decides the outcome
	// deep sleep (op 2) comes at random in any mode; in high-speed run it is refused
	always @(negedge CLK)
	begin
		req.wait_for_interrupt_instruction      <= (op == 3'h1) || (op == 3'h2);
		req.deep     <= (op == 3'h2);
		req.go_high_speed_run_mode <= (op == 3'h3);
		req.go_very_low_power_run  <= (op == 3'h4);
		req.go_run   <= (op == 3'h5);
	end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the low power mode controller
`timescale 1ns/10ps
module tb;
	logic                    CLK = 1'b0;
	logic                    SRST = 1'b1;
	logic                    CE = 1'b1;
	logic                    IRQ = 1'b0;
	logic                    ASYNC_WAKE = 1'b0;
	logic [2:0]              op = 3'h0;
	lpmc_pkg::lpmc_req_type  req;
	lpmc_pkg::lpmc_mode_type mode;
	lpmc_pkg::lpmc_ctrl_type ctrl;
	logic                    rej;
	int                      error_cnt = 0;
	int                      samples_checked = 0;
	int                      m = 0;
	logic                    m_rej = 1'b0;
	logic                    s1 = 1'b0;
	logic                    s2 = 1'b0;
	// expected controls and the bits fixed per mode; others left open
	logic [12:0]             ev [7] = '{13'h1EC6, 13'h100C, 13'h0A04,
		13'h0144, 13'h1034, 13'h0634, 13'h0107};
	logic [12:0]             em [7] = '{13'h1FFF, 13'h100C, 13'h1A04,
		13'h1B44, 13'h10F4, 13'h16F4, 13'h0FC7};

	lpmc_core_model lpmc_core_model_inst (.CLK(CLK), .op(op), .req(req));
	lpmc_top lpmc_top_inst
	(
		.CLK           (CLK),
		.SRST          (SRST),
		.CE            (CE),
		.REQ           (req),
		.IRQ           (IRQ),
		.ASYNC_WAKE    (ASYNC_WAKE),
		.MODE          (mode),
		.CTRL          (ctrl),
		.STOP_REJECTED (rej)
	);

	always #50 CLK = ~CLK;

	// reference mode sequence; wake line passes two flops before use
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			m <= 0;
			m_rej <= 1'b0;
			s1 <= 1'b0;
			s2 <= 1'b0;
		end
		else if (CE)
		begin
			s1 <= ASYNC_WAKE;
			s2 <= s1;
			m_rej <= (m == 1) && req.wait_for_interrupt_instruction && req.deep;
			case (m)
				0: m <= req.wait_for_interrupt_instruction ? (req.deep ? 3 : 2) :
					req.go_high_speed_run_mode ? 1 : req.go_very_low_power_run ? 4 : 0;
				1: m <= (req.wait_for_interrupt_instruction && !req.deep) ? 2 : req.go_run ? 0 : 1;
				2: m <= IRQ ? 0 : 2;
				3: m <= (IRQ || s2) ? 0 : 3;
				4: m <= req.wait_for_interrupt_instruction ? (req.deep ? 6 : 5) : req.go_run ? 0 : 4;
				5: m <= IRQ ? 4 : 5;
				default: m <= (IRQ || s2) ? 4 : 6;
			endcase
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic compare;
		check(16'(mode), 16'(m));
		check(16'(ctrl & em[m]), 16'(ev[m]));
		check(16'(ctrl & em[m]), 16'(ev[m]));
		check(16'(rej), 16'(m_rej));
	endtask

	initial
	begin
		void'($urandom(60));
		repeat (10) @(posedge CLK);
		@(negedge CLK);
		SRST <= 1'b0;
		check(16'(ctrl), 16'h1EC6);
		check(16'(mode), 16'h0000);
		// random one-hot requests; a reset lands once in mid-run
		for (int i = 0; i < 4000; i++)
		begin
			@(negedge CLK);
			compare();
			op <= 3'($urandom % 8);
			IRQ <= ($urandom % 8) == 0;
			ASYNC_WAKE <= ($urandom % 16) == 0;
			CE <= ($urandom % 16) != 0;
			SRST <= (i == 2000);
		end
		report_and_stop();
	end
endmodule
